// ### sram_ctl.v
// Host-side controller that drives a 256K x 4 asynchronous static memory.
// Assumes the memory sits on board pins; read data arrives asynchronously
// and is synchronised by two flip-flops before use. One clock, no bus.
`include "sram_ctl_defines.vh"
`default_nettype none
// Notes on behaviour
// - Strobe stays high throughout every read.
// - Space write cycles by write cycle time.
// - Select asserted long enough before write end.
// - Address stable long enough before write end.
// - Data valid long enough before write end.
// - Change address only while select or strobe high.
module sram_ctl #(
  parameter AW = 18,
  parameter DW = 4,
  parameter TW = 4
) (
  input wire clk_sys,
  input wire rst_n,
  input wire slow_grade,
  input wire req_valid,
  input wire req_write,
  input wire [AW-1:0] req_addr,
  input wire [DW-1:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg [DW-1:0] rsp_rdata,
  output reg [AW-1:0] word_address,
  output reg [DW-1:0] write_data_in,
  output reg select_n,
  output reg write_n,
  input wire [DW-1:0] read_data_out
);
  // ---------------------------------
  // States
  // ---------------------------------
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_READ = 3'd1;
  localparam [2:0] S_RSMP = 3'd2;
  localparam [2:0] S_WSETUP = 3'd3;
  localparam [2:0] S_WPULSE = 3'd4;
  localparam [2:0] S_GAP = 3'd5;

  // Cycles covering a time in ns, rounded up, plus extra whole cycles;
  // the result is cut to the timer width on purpose
  function [TW-1:0] to_cyc;
    input integer ns;
    input integer extra;
    integer total;
    begin
      total = `NS_TO_CYC_UP(ns) + extra;
      to_cyc = total[TW-1:0];
    end
  endfunction

  // Cycle counts per grade, all least times rounded up
  localparam [TW-1:0] F_RD = to_cyc(`FAST_ACCESS_NS, `READ_MARGIN_CYC);
  localparam [TW-1:0] S_RD = to_cyc(`SLOW_ACCESS_NS, `READ_MARGIN_CYC);
  localparam [TW-1:0] F_WP = to_cyc(`FAST_WRITE_PULSE_NS, 0);
  localparam [TW-1:0] S_WP = to_cyc(`SLOW_WRITE_PULSE_NS, 0);
  localparam [TW-1:0] F_CS = to_cyc(`FAST_SELECT_TO_END_NS, 0);
  localparam [TW-1:0] S_CS = to_cyc(`SLOW_SELECT_TO_END_NS, 0);
  localparam [TW-1:0] F_AW = to_cyc(`FAST_ADDR_TO_END_NS, 0);
  localparam [TW-1:0] S_AW = to_cyc(`SLOW_ADDR_TO_END_NS, 0);
  localparam [TW-1:0] F_DW = to_cyc(`FAST_DATA_TO_END_NS, 0);
  localparam [TW-1:0] S_DW = to_cyc(`SLOW_DATA_TO_END_NS, 0);
  localparam [TW-1:0] F_WC = to_cyc(`FAST_WRITE_CYCLE_NS, 0);
  localparam [TW-1:0] S_WC = to_cyc(`SLOW_WRITE_CYCLE_NS, 0);
  // Idle gap between accesses, in cycles
  localparam [TW-1:0] GAP_V = to_cyc(0, `GAP_CYC);

  // Larger of two counts
  function [TW-1:0] max2;
    input [TW-1:0] a;
    input [TW-1:0] b;
    begin
      max2 = (a > b) ? a : b;
    end
  endfunction

  // Pick a grade's count
  function [TW-1:0] pick;
    input sel;
    input [TW-1:0] fast;
    input [TW-1:0] slow;
    begin
      pick = sel ? slow : fast;
    end
  endfunction

  // Strobe low time: covers pulse width, select, address and data setup
  wire [TW-1:0] strobe_cyc = max2(max2(pick(slow_grade, F_WP, S_WP), pick(slow_grade, F_CS, S_CS)),
    max2(pick(slow_grade, F_AW, S_AW), pick(slow_grade, F_DW, S_DW)));
  // Total write cycle, rest of it spent in gap after strobe rises
  wire [TW-1:0] wcycle_cyc = pick(slow_grade, F_WC, S_WC);
  wire [TW-1:0] read_cyc = pick(slow_grade, F_RD, S_RD);

  reg [2:0] state_q;
  reg [2:0] state_d;
  // Read data synchroniser
  reg [DW-1:0] rd_meta_q;
  reg [DW-1:0] rd_sync_q;
  // Timer control
  reg tmr_load;
  reg [TW-1:0] tmr_value;
  wire tmr_done;

  sram_phase_timer #(.W(TW)) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(tmr_load),
    .value(tmr_value),
    .done(tmr_done)
  );

  // ---------------------------------
  // Read data synchroniser, two stages
  // ---------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_meta_q <= {DW{1'b0}};
      rd_sync_q <= {DW{1'b0}};
    end else begin
      rd_meta_q <= read_data_out;
      rd_sync_q <= rd_meta_q;
    end
  end

  // ---------------------------------
  // Next state and timer loads
  // ---------------------------------
  always @* begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_value = {TW{1'b0}};
    case (state_q)
      S_IDLE: begin
        // Memory may idle deselected indefinitely
        if (req_valid && req_ready) begin
          tmr_load = 1'b1;
          if (req_write) begin
            // Two cycles of setup with strobe high before it falls
            state_d = S_WSETUP;
            tmr_value = {{(TW-1){1'b0}}, 1'b1};
          end else begin
            // Wait the access time plus two sync stages
            state_d = S_READ;
            tmr_value = read_cyc + 2'd2;
          end
        end
      end
      S_READ: begin
        if (tmr_done) begin
          state_d = S_RSMP;
        end
      end
      S_RSMP: begin
        state_d = S_GAP;
        tmr_load = 1'b1;
        tmr_value = GAP_V;
      end
      S_WSETUP: begin
        if (tmr_done) begin
          state_d = S_WPULSE;
          tmr_load = 1'b1;
          tmr_value = strobe_cyc;
        end
      end
      S_WPULSE: begin
        if (tmr_done) begin
          // Remaining write cycle time, at least one cycle
          state_d = S_GAP;
          tmr_load = 1'b1;
          tmr_value = (wcycle_cyc > strobe_cyc + 1'b1) ?
            wcycle_cyc - strobe_cyc - 1'b1 : GAP_V;
        end
      end
      S_GAP: begin
        if (tmr_done) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ---------------------------------
  // State register and pin drive
  // ---------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      select_n <= 1'b1;
      write_n <= 1'b1;
      word_address <= {AW{1'b0}};
      write_data_in <= {DW{1'b0}};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DW{1'b0}};
    end else begin
      state_q <= state_d;
      rsp_valid <= 1'b0;
      req_ready <= (state_d == S_IDLE) && !(req_valid && req_ready);
      if (state_q == S_IDLE && req_valid && req_ready) begin
        // Address and data change only while strobe is high
        word_address <= req_addr;
        write_data_in <= req_wdata;
        select_n <= 1'b0;
        write_n <= 1'b1;
      end
      if (state_q == S_WSETUP && tmr_done) begin
        write_n <= 1'b0;
      end
      if (state_q == S_WPULSE && tmr_done) begin
        // Release strobe and select together; data held past the end
        write_n <= 1'b1;
        select_n <= 1'b1;
      end
      if (state_q == S_RSMP) begin
        // Data captured only after access time, avoiding float window
        rsp_rdata <= rd_sync_q;
        rsp_valid <= 1'b1;
        select_n <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### sram_ctl_checker.sv
// Pin-level checks for the static memory controller.
// Assumes it is bound into sram_ctl; one clock, async active-low reset.
`default_nettype none
module sram_ctl_checker #(
  parameter AW = 18,
  parameter DW = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow_grade,
  input wire logic rsp_valid,
  input wire logic [AW-1:0] word_address,
  input wire logic [DW-1:0] write_data_in,
  input wire logic select_n,
  input wire logic write_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [3:0] gap_q; // Cycles since the address moved, saturating
  logic [AW-1:0] prev_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 4'hF;
      prev_q <= {AW{1'b0}};
    end else begin
      prev_q <= word_address;
      gap_q <= (word_address != prev_q) ? 4'h1 : gap_q + {3'h0, gap_q != 4'hF};
    end
  end
  sequence wr_start; $fell(write_n); endsequence
  sequence wr_end; $rose(write_n); endsequence
  a_addr_quiet_write: assert property (!$stable(word_address) |-> select_n || write_n)
    else $error("address moved inside a write");
  a_pulse_width: assert property (wr_start |-> (!write_n)[*4] ##1 (!write_n || !slow_grade))
    else $error("write strobe too short");
  a_sel_before_end: assert property (wr_end |-> !$past(select_n, 4) && (!slow_grade || !$past(select_n, 7)))
    else $error("select too late before write end");
  a_addr_before_end: assert property (wr_end |->
    $past(word_address, 1) == $past(word_address, 5)
    && (!slow_grade || $past(word_address, 1) == $past(word_address, 7)))
    else $error("address too late before write end");
  a_data_before_end: assert property (wr_end |->
    $past(write_data_in, 1) == $past(write_data_in, 3)
    && (!slow_grade || $past(write_data_in, 1) == $past(write_data_in, 4)))
    else $error("data too late before write end");
  a_strobe_in_read: assert property (rsp_valid |-> $past(write_n, 2) && $past(write_n, 6))
    else $error("strobe low during read");
  a_read_access: assert property (rsp_valid |->
    !$past(select_n, 3) && !$past(select_n, 9)
    && (!slow_grade || !$past(select_n, 11)))
    else $error("read sampled before access time");
  a_cycle_spacing: assert property (word_address != prev_q |-> gap_q >= (slow_grade ? 4'h9 : 4'h7))
    else $error("cycles spaced too closely");
endmodule
bind sram_ctl sram_ctl_checker #(.AW(AW), .DW(DW)) chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .slow_grade(slow_grade), .rsp_valid(rsp_valid), .word_address(word_address),
  .write_data_in(write_data_in), .select_n(select_n), .write_n(write_n));
`default_nettype wire

// ### sram_ctl_defines.vh
// Timing constants for the host-side controller of the 256K x 4 static memory.
// Assumes a 250 MHz system clock; times are in ns, counts in clock cycles.
`ifndef SRAM_CTL_DEFINES_VH
`define SRAM_CTL_DEFINES_VH
`define CLK_PERIOD_NS 4
// Fast grade times (ns)
`define FAST_ACCESS_NS 25
`define FAST_WRITE_CYCLE_NS 25
`define FAST_SELECT_TO_END_NS 16
`define FAST_ADDR_TO_END_NS 18
`define FAST_WRITE_PULSE_NS 15
`define FAST_DATA_TO_END_NS 10
// Slow grade times (ns)
`define SLOW_ACCESS_NS 35
`define SLOW_WRITE_CYCLE_NS 35
`define SLOW_SELECT_TO_END_NS 26
`define SLOW_ADDR_TO_END_NS 28
`define SLOW_WRITE_PULSE_NS 20
`define SLOW_DATA_TO_END_NS 15
// Least times round up to whole cycles
`define NS_TO_CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Pin-delay margin in cycles added to the read sample point
`define READ_MARGIN_CYC 1
// Idle cycles with select high between back-to-back accesses
`define GAP_CYC 1
`endif

// ### sram_ctl_tb.sv
// Self-checking bench for the static memory controller.
// Assumes the behavioural memory model on the pins and a 250 MHz clock.
`default_nettype none
module sram_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic slow_grade = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [17:0] req_addr = 18'h00000;
  logic [3:0] req_wdata = 4'h0;
  wire req_ready, rsp_valid, select_n, write_n;
  wire [3:0] rsp_rdata, write_data_in, read_data_out;
  wire [17:0] word_address;
  int err_total = 0;
  int cmp_count = 0;
  logic [3:0] shadow [logic [17:0]];
  logic [17:0] addrs [8];
  always #2 clk_sys = ~clk_sys;
  sram_ctl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .slow_grade(slow_grade),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .word_address(word_address), .write_data_in(write_data_in), .select_n(select_n),
    .write_n(write_n), .read_data_out(read_data_out));
  sram_model mem_u (.slow(slow_grade), .word_address(word_address),
    .write_data_in(write_data_in), .select_n(select_n), .write_n(write_n),
    .read_data_out(read_data_out));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [3:0] expect_of(input logic [17:0] a);
    return shadow[a];
  endfunction
  // One request, held until the edge that takes it
  task automatic op(input logic w, input logic [17:0] a, input logic [3:0] d);
    int k;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge clk_sys); while (req_ready !== 1'b1);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    if (w) shadow[a] = d;
    else begin
      for (k = 0; k < 40 && rsp_valid !== 1'b1; k++) @(negedge clk_sys);
      check(rsp_valid, 32'h1);
      check(rsp_rdata, expect_of(a));
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial begin
    int i;
    void'($urandom(32'hCBBF));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      @(posedge clk_sys);
      slow_grade <= g[0];
      addrs[0] = 18'h00000; // Corner addresses plus random ones
      addrs[1] = 18'h3FFFF;
      for (i = 2; i < 8; i++) addrs[i] = 18'($urandom);
      for (i = 0; i < 8; i++) op(1'b1, addrs[i], 4'($urandom));
      op(1'b1, addrs[1], ~expect_of(addrs[1]));
      for (i = 0; i < 8; i++) op(1'b0, addrs[i], 4'h0);
    end
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check({select_n, write_n, req_ready}, 32'h6);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) op(1'b0, addrs[i], 4'h0);
    end_of_test();
  end
endmodule
`default_nettype wire

// ### sram_model.sv
// Behavioural 256K x 4 static memory on the controller's pins.
// Assumes the bench sets the speed grade; floating outputs show garbage.
`default_nettype none
module sram_model (
  input wire logic slow,
  input wire logic [17:0] word_address,
  input wire logic [3:0] write_data_in,
  input wire logic select_n,
  input wire logic write_n,
  output logic [3:0] read_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem [0:262143];
  logic [17:0] wa;
  logic [3:0] wd;
  logic [3:0] last = 4'h5;
  logic armed = 1'b0;
  logic ok = 1'b0;
  int gen = 0;
  // Hold the target while a write is open, commit when it closes
  always @(select_n, write_n, word_address, write_data_in) begin
    if (!select_n && !write_n) begin
      wa = word_address;
      wd = write_data_in;
      armed = 1'b1;
    end
  end
  // Rising select or strobe closes an open write and commits it; contents are kept
  always @(posedge select_n, posedge write_n) begin
    if (armed) mem[wa] = wd;
    armed = 1'b0;
  end
  // Output is valid only a full access time after any change
  always @(select_n, write_n, word_address) begin
    gen = gen + 1;
    ok = 1'b0;
    fork
      automatic int g = gen;
      begin
        #(slow ? 35 : 25);
        if (g == gen) ok = !select_n && write_n;
      end
    join_none
  end
  always @(posedge ok) last = mem[word_address];
  // Data is dropped at once on any change, harsher than the part's hold
  // and float windows, so the controller must not lean on them
  assign read_data_out = ok ? mem[word_address] : ~last;
endmodule
`default_nettype wire

// ### sram_phase_timer.v
// Down-counter that times one phase of a memory cycle.
// Assumes a single clock; load and count come from the controller.
`default_nettype none
module sram_phase_timer #(
  parameter W = 4
) (
  input wire clk_sys,
  input wire rst_n,
  input wire load,
  input wire [W-1:0] value,
  output wire done
);
  // Remaining cycles of the current phase
  reg [W-1:0] count_q;
  // -------------------------------
  // Count down, load wins
  // -------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= {W{1'b0}};
    end else if (load) begin
      count_q <= value;
    end else if (count_q != {W{1'b0}}) begin
      count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  // Done looks at the count alone: the controller derives load from done,
  // so gating done with load would close a combinational loop.
  assign done = (count_q == {W{1'b0}});
endmodule
`default_nettype wire
